/* File: logic/pmdw_cfg.svh */
// constants for the program memory data window
`ifndef PMDW_CFG_SVH
`define PMDW_CFG_SVH
`define PMDW_WIN_BASE     8'h40
`define PMDW_WIN_LAST     8'h7f
`define PMDW_PAGE_ADDR    8'hc9
`define PMDW_OFS_BITS     6
`define PMDW_PAGE_BITS    7
`define PMDW_PAGE_MSB     6
`define PMDW_READ_FILL    8'hff
`define PMDW_RDATA_RST    8'h00
`endif

/* File: logic/pmdw_pkg.sv */
// types shared by the program memory data window
package pmdw_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmdw_dreq_s;

  typedef struct packed {
    logic        rd;
    logic [12:0] addr;
  } pmdw_preq_s;
endpackage

/* File: logic/pmdw_page_reg.sv */
// write-only page register of the data window
`timescale 1ns/1ns
`include "pmdw_cfg.svh"
module pmdw_page_reg #(
  parameter int PAGE_W = `PMDW_PAGE_BITS
) (
  input  wire logic              clk_i,
  input  wire logic              wr_i,
  input  wire logic [7:0]        wdata_i,
  output logic      [PAGE_W-1:0] page_o
);
  logic [PAGE_W-1:0] page_reg;

  // no reset: contents stay undefined until the first write
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      page_reg <= wdata_i[PAGE_W-1:0];
    end
  end

  assign page_o = page_reg;
endmodule // pmdw_page_reg

/* File: logic/pmdw_window.sv */
// program memory data window: maps data-space reads onto program memory
//
// Summary of operation
// - data addresses 40h to 7fh form a read-only window whose reads go to program memory, not ram.
// - each window read returns one byte of a 64-byte block anywhere in program memory 0000h to 1fffh.
// - writing the page register moves the window to another 64-byte aligned block.
// - the program address is the page value on top of the six low data address bits.
// - the page register sits at data address c9h, takes byte writes and never returns its value on read.
// - page bits 6 to 0 form the upper program address and bit 7 is ignored.
// - the page register is not reset and is undefined until first written.
`timescale 1ns/1ns
`include "pmdw_cfg.svh"
module pmdw_window (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire pmdw_pkg::pmdw_dreq_s dreq_i,
  input  wire logic [7:0]         pdata_i,
  output pmdw_pkg::pmdw_preq_s    preq_o,
  output logic                    win_hit_o,
  output logic                    page_hit_o,
  output logic                    rvalid_o,
  output logic [7:0]              rdata_o
);
  import pmdw_pkg::*;

  localparam int PW = `PMDW_PAGE_BITS;
  localparam int OW = `PMDW_OFS_BITS;

  logic [PW-1:0] page;
  wire           in_win;
  wire           at_page;
  wire           win_rd;
  wire           page_wr;
  logic          rd_pend_reg;
  logic          rd_pend_next;
  logic [7:0]    rdata_reg;
  logic [7:0]    rdata_next;
  // tracks whether the page holds a written value; the page itself is never reset
  logic          loaded_reg;

  assign in_win  = (dreq_i.addr >= `PMDW_WIN_BASE) && (dreq_i.addr <= `PMDW_WIN_LAST);
  assign at_page = (dreq_i.addr == `PMDW_PAGE_ADDR);
  assign win_rd  = in_win && dreq_i.rd;
  assign page_wr = at_page && dreq_i.wr;

  pmdw_page_reg #(
    .PAGE_W (PW)
  ) u_page (
    .clk_i   (clk_i),
    .wr_i    (page_wr),
    .wdata_i (dreq_i.wdata),
    .page_o  (page)
  );

  // program side is read only; window writes never reach it
  assign preq_o.rd   = win_rd;
  assign preq_o.addr = {page, dreq_i.addr[OW-1:0]};
  assign win_hit_o   = in_win;
  assign page_hit_o  = at_page;

  // reading the page register returns a fixed fill, never its content
  assign rd_pend_next = win_rd || (at_page && dreq_i.rd);
  assign rdata_next   = win_rd ? pdata_i : `PMDW_READ_FILL;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_pend_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= `PMDW_RDATA_RST;
    end else if (rd_pend_next) begin
      rdata_reg <= rdata_next;
    end
  end

  // checker helper only: an undefined page must not trip the hold check
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loaded_reg <= 1'b0;
    end else if (page_wr) begin
      loaded_reg <= 1'b1;
    end
  end

  assign rvalid_o = rd_pend_reg;
  assign rdata_o  = rdata_reg;

  // checks
  sequence page_load_s;
    page_wr;
  endsequence

  window_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    win_rd |-> preq_o.addr[OW-1:0] == dreq_i.addr[OW-1:0])
    else $error("window low address bits wrong");

  page_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    page_load_s ##1 win_rd |-> preq_o.addr[12:OW] == $past(dreq_i.wdata[PW-1:0]))
    else $error("window page not taken from last write");

  bit7_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    page_load_s |=> page == $past(dreq_i.wdata[PW-1:0]))
    else $error("page register did not load bits 6 to 0");

  window_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    preq_o.rd |-> dreq_i.addr[7:OW] == 2'b01)
    else $error("program read outside window");

  no_pm_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dreq_i.wr && !dreq_i.rd) |-> !preq_o.rd)
    else $error("write reached program memory");

  window_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    win_rd |=> rvalid_o && rdata_o == $past(pdata_i))
    else $error("window read data wrong");

  page_hidden_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (at_page && dreq_i.rd) |=> rdata_o == `PMDW_READ_FILL)
    else $error("page register read leaked content");

  page_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (loaded_reg && !page_wr) |=> $stable(page))
    else $error("page changed without write");

  read_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rvalid_o |-> $past(win_rd || (at_page && dreq_i.rd)))
    else $error("read answer without a read");

  rdata_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !dreq_i.rd |=> $stable(rdata_o))
    else $error("read data changed without a read");
endmodule // pmdw_window

/* File: verif/pmdw_pmem_model.sv */
// program memory model answering the window's fetch address
`timescale 1ns/1ns
module pmdw_pmem_model (
  input  wire logic                 clk_i,
  input  wire pmdw_pkg::pmdw_preq_s preq_i,
  output logic [7:0]                pdata_o
);
  import pmdw_pkg::*;
  logic [7:0] idle_reg = 8'h5a;
  // not fetching: bus toggles so a stale byte is never mistaken for data
  always @(posedge clk_i) idle_reg <= ~idle_reg;
  assign pdata_o = preq_i.rd ? preq_i.addr[7:0] ^ {preq_i.addr[12:8], 3'h5} : idle_reg;
endmodule // pmdw_pmem_model

/* File: verif/testbench.sv */
// self-checking bench of the program memory data window
`timescale 1ns/1ns
`include "pmdw_cfg.svh"
module testbench;
  import pmdw_pkg::*;
  logic       clk_i = 0, rst_i = 1, win_hit, page_hit, rvalid;
  logic [7:0] pdata, rdata;
  pmdw_dreq_s dreq = '0;
  pmdw_preq_s preq;
  int         err_total = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  pmdw_window pmdw_window_inst (.clk_i(clk_i), .rst_i(rst_i), .dreq_i(dreq), .pdata_i(pdata),
    .preq_o(preq), .win_hit_o(win_hit), .page_hit_o(page_hit), .rvalid_o(rvalid), .rdata_o(rdata));
  pmdw_pmem_model pmdw_pmem_model_inst (.clk_i(clk_i), .preq_i(preq), .pdata_o(pdata));
  task automatic chk(input string n, input logic [12:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    #1 dreq = '{1'b0, 1'b1, a, d};
    #1 chk("preq_rd", 0, preq.rd);
    @(posedge clk_i);
    #1 dreq.wr = 0;
  endtask
  // rvalid is fixed one cycle after the read, so no wait loop is needed
  task automatic rd(input logic [7:0] a, input logic [12:0] pa, input logic hit);
    @(posedge clk_i);
    #1 dreq = '{1'b1, 1'b0, a, 8'h00};
    #1 chk("win_hit", hit, win_hit);
    chk("page_hit", a == `PMDW_PAGE_ADDR, page_hit);
    chk("preq_rd", hit, preq.rd);
    if (hit) chk("preq_addr", pa, preq.addr);
    @(posedge clk_i);
    #1 dreq.rd = 0;
    chk("rvalid", hit | (a == `PMDW_PAGE_ADDR), rvalid);
    if (hit) chk("rdata", pa[7:0] ^ {pa[12:8], 3'h5}, rdata);
    else if (a == `PMDW_PAGE_ADDR) chk("rdata", `PMDW_READ_FILL, rdata);
  endtask
  initial begin
    #100000 err_total++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_i = 0;
    // only bits 6 to 0 of a page write reach the page; bit 7 is dropped
    wr(8'hc9, 8'hff);
    rd(8'h40, 13'h1fc0, 1);
    rd(8'h7f, 13'h1fff, 1);
    rd(8'h3f, 13'h0, 0);
    rd(8'h80, 13'h0, 0);
    wr(8'hc9, 8'h05);
    wr(8'h45, 8'h00);
    rd(8'h45, 13'h0145, 1);
    rd(8'hc9, 13'h0, 0);
    @(posedge clk_i);
    #1 rst_i = 1;
    #1 chk("rdata_rst", 0, rdata);
    chk("rvalid_rst", 0, rvalid);
    @(posedge clk_i);
    #1 rst_i = 0;
    wr(8'hc9, 8'h85);
    rd(8'h45, 13'h0145, 1);
    stop_test();
  end
endmodule // testbench
